// ### core/legacy_env_pkg.sv
// Package of constants and types for the legacy environment integrity checker
package legacy_env_pkg;
  // Flag bit positions
  localparam int unsigned CF_POS = 0;
  localparam int unsigned ONE_POS = 1;
  localparam int unsigned PF_POS = 2;
  localparam int unsigned Z3_POS = 3;
  localparam int unsigned AF_POS = 4;
  localparam int unsigned Z5_POS = 5;
  localparam int unsigned ZF_POS = 6;
  localparam int unsigned SF_POS = 7;
  localparam int unsigned TF_POS = 8;
  localparam int unsigned IF_POS = 9;
  localparam int unsigned DF_POS = 10;
  localparam int unsigned OF_POS = 11;
  localparam int unsigned IOPL_LO = 12;
  localparam int unsigned NT_POS = 14;
  localparam int unsigned Z15_POS = 15;
  localparam int unsigned RF_POS = 16;
  localparam int unsigned VM_POS = 17;
  localparam int unsigned AC_POS = 18;
  localparam int unsigned VIF_POS = 19;
  localparam int unsigned VIP_POS = 20;
  localparam int unsigned ID_POS = 21;
  // Writable mask: bits 0,2,4,6..14,16..21
  localparam logic [63:0] FLAGS_WR_MASK = 64'h0000_0000_003F_7FD5;
  localparam logic [63:0] FLAGS_ONES = 64'h0000_0000_0000_0002;
  localparam logic [63:0] FLAGS_RESET = 64'h0000_0000_0000_0002;
  // Descriptor type codes (4-bit type field, bit3 = code)
  localparam logic [3:0] TYPE_CODE_BIT = 4'h8;
  localparam logic [3:0] TYPE_EXPDN_BIT = 4'h4;
  localparam logic [3:0] TYPE_WR_BIT = 4'h2;
  localparam logic [3:0] TYPE_RD_BIT = 4'h2;
  localparam logic [1:0] CPL_REAL = 2'h0;
  localparam logic [1:0] CPL_VM86 = 2'h3;
  localparam logic [15:0] ERR_ZERO = 16'h0000;
  localparam int unsigned RST_SYNC_LEN = 2;

  typedef enum logic [1:0] {
    MODE_REAL = 2'b00,
    MODE_PROT = 2'b01,
    MODE_VM86 = 2'b10
  } legacy_mode_e;

  typedef enum logic [2:0] {
    REF_FETCH = 3'b000,
    REF_SS = 3'b001,
    REF_DATA = 3'b010,
    REF_CS = 3'b011,
    REF_TABLE = 3'b100
  } ref_kind_e;

  typedef enum logic [1:0] {
    FAULT_NONE = 2'b00,
    FAULT_GP = 2'b01,
    FAULT_STACK = 2'b10
  } fault_kind_e;
endpackage

// ### core/legacy_check_if.sv
// Interface carrying one check request and its verdict between checker modules
`timescale 1ns/1ps
interface legacy_check_if;
  import legacy_env_pkg::*;
  logic req;
  ref_kind_e kind;
  logic is_write;
  legacy_mode_e mode;
  logic [1:0] cpl;
  logic [3:0] dtype;
  logic [1:0] dpl;
  logic dbit;
  logic sbit;
  logic pbit;
  logic abit;
  logic [15:0] selector;
  logic fault;
  fault_kind_e fkind;
  logic [15:0] err_code;
  logic high_prio;
  modport top (output req, kind, is_write, mode, cpl, dtype, dpl, dbit, sbit, pbit, abit, selector,
    input fault, fkind, err_code, high_prio);
  modport chk (input req, kind, is_write, mode, cpl, dtype, dpl, dbit, sbit, pbit, abit, selector,
    output fault, fkind, err_code, high_prio);
endinterface

// ### core/legacy_ref_checker.sv
// Combinational descriptor and privilege checks for one legacy reference
`timescale 1ns/1ps
module legacy_ref_checker
  import legacy_env_pkg::*;
(
  legacy_check_if.chk chk
);
  // Data expand-down: not code, expand-down bit set
  function automatic logic is_expdn(input logic [3:0] t);
    is_expdn = ((t & TYPE_CODE_BIT) == 4'h0) && ((t & TYPE_EXPDN_BIT) != 4'h0);
  endfunction

  // Readable: data always readable, code only with read bit
  function automatic logic is_readable(input logic [3:0] t);
    is_readable = ((t & TYPE_CODE_BIT) == 4'h0) || ((t & TYPE_RD_BIT) != 4'h0);
  endfunction

  function automatic logic is_writable(input logic [3:0] t);
    is_writable = ((t & TYPE_CODE_BIT) == 4'h0) && ((t & TYPE_WR_BIT) != 4'h0);
  endfunction

  logic bad;
  logic rw_bad;
  logic spa_bad;

  // Only listed fields are tested; the rest pass untouched
  always_comb
  begin
    bad = 1'b0;
    rw_bad = chk.is_write ? !is_writable(chk.dtype) : !is_readable(chk.dtype);
    spa_bad = !(chk.sbit && chk.pbit && chk.abit);
    case (chk.kind)
      REF_FETCH:
      begin
        // Privilege must match the mode's fixed level
        if (chk.mode == MODE_REAL && chk.cpl != CPL_REAL) bad = 1'b1; // RULE11
        if (chk.mode == MODE_VM86 && chk.cpl != CPL_VM86) bad = 1'b1; // RULE11
        if (chk.mode == MODE_VM86 && chk.dpl != CPL_VM86) bad = 1'b1;
        if (is_expdn(chk.dtype)) bad = 1'b1; // RULE6
        if (spa_bad) bad = 1'b1;
      end
      REF_SS:
      begin
        if (chk.dpl != chk.cpl) bad = 1'b1;
        if (chk.mode == MODE_VM86 && (chk.dbit || is_expdn(chk.dtype))) bad = 1'b1;
        if (rw_bad || spa_bad) bad = 1'b1;
      end
      REF_DATA:
      begin
        if (rw_bad || spa_bad) bad = 1'b1;
      end
      REF_CS:
      begin
        if (chk.mode == MODE_VM86 && (chk.dbit || is_expdn(chk.dtype))) bad = 1'b1;
        if (chk.mode == MODE_PROT && rw_bad) bad = 1'b1; // RULE7 RULE8
        if (spa_bad) bad = 1'b1;
      end
      REF_TABLE:
      begin
        if (chk.sbit || !chk.pbit) bad = 1'b1;
      end
      default:
      begin
        bad = 1'b0;
      end
    endcase
  end

  // Verdict and error code
  always_comb
  begin
    chk.fault = chk.req && bad;
    chk.high_prio = chk.req && bad && (chk.kind == REF_FETCH); // RULE5
    if (!chk.fault) chk.fkind = FAULT_NONE;
    else if (chk.kind == REF_SS) chk.fkind = FAULT_STACK; // RULE10
    else chk.fkind = FAULT_GP;
    chk.err_code = (chk.fault && chk.kind == REF_TABLE) ? chk.selector : ERR_ZERO; // RULE9
  end
endmodule // legacy_ref_checker

// ### core/legacy_env_integrity_check.sv
// Legacy environment run-time integrity checker and legacy flags word
`timescale 1ns/1ps
//
// Function
// (RULE1) Extra checks whenever legacy code runs
// (RULE2) Check only on fetch or named segment
// (RULE3) No checks at instruction set switch
// (RULE4) Unlisted descriptor fields stay unchecked
// (RULE5) Fetch faults: high priority, code zero
// (RULE6) Fetch faults on data expand-down code segment
// (RULE7) Protected mode enforces code segment read/write
// (RULE8) Real and virtual-8086 skip those checks
// (RULE9) Table faults report selector, else zero
// (RULE10) Stack segment violations raise stack faults
// (RULE11) Fetch needs privilege 0 real, 3 virtual
// (RULE12) Arithmetic flags at fixed positions
// (RULE13) System flags at fixed positions
// (RULE14) Bit one ignores writes, reads one
// (RULE15) Bits 3, 5, 15 read zero
// (RULE16) Software writes zero to bits 63:22
// (RULE17) Flags never affect native instructions
// (RULE18) Flags visible on entry, kept after exit
module legacy_env_integrity_check
  import legacy_env_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Execution state
  input wire logic i_legacy_active,
  input wire logic i_iset_switch,
  input wire logic i_protection_on,
  input wire logic [1:0] i_current_privilege_level,
  // Reference request
  input wire logic i_ref_valid,
  input wire ref_kind_e i_ref_kind,
  input wire logic i_ref_write,
  input wire logic [3:0] i_desc_type,
  input wire logic [1:0] i_desc_dpl,
  input wire logic i_desc_dbit,
  input wire logic i_desc_sbit,
  input wire logic i_desc_pbit,
  input wire logic i_desc_abit,
  input wire logic [15:0] i_desc_selector,
  // Flags word access
  input wire logic i_flags_wr,
  input wire logic i_flags_wr_legacy,
  input wire logic [63:0] i_flags_wdata,
  // Fault report
  output logic o_general_protection_fault,
  output logic o_stack_fault,
  output logic o_fault_high_prio,
  output logic [15:0] o_fault_err_code,
  // Flags view
  output logic [63:0] o_legacy_flags_word,
  output logic o_virtual_8086_mode
);
  logic [RST_SYNC_LEN-1:0] rst_sync_ff;
  logic rstn;
  logic [63:0] flags_ff;
  logic [63:0] nxt_flags;
  legacy_mode_e mode;
  logic gp_ff;
  logic ss_ff;
  logic prio_ff;
  logic [15:0] err_ff;

  legacy_check_if chk_bus ();

  // Reset release through two flops
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn) rst_sync_ff <= '0;
    else rst_sync_ff <= {rst_sync_ff[RST_SYNC_LEN-2:0], 1'b1};
  end
  assign rstn = rst_sync_ff[RST_SYNC_LEN-1];

  // Mode from protection bit and the virtual-8086 flag
  always_comb
  begin
    if (flags_ff[VM_POS]) mode = MODE_VM86;
    else if (i_protection_on) mode = MODE_PROT;
    else mode = MODE_REAL;
  end

  // Gate requests: only legacy references, never on a switch cycle
  assign chk_bus.req = i_ref_valid && i_legacy_active && !i_iset_switch; // RULE1 RULE2 RULE3
  assign chk_bus.kind = i_ref_kind;
  assign chk_bus.is_write = i_ref_write;
  assign chk_bus.mode = mode;
  assign chk_bus.cpl = i_current_privilege_level;
  assign chk_bus.dtype = i_desc_type;
  assign chk_bus.dpl = i_desc_dpl;
  assign chk_bus.dbit = i_desc_dbit;
  assign chk_bus.sbit = i_desc_sbit;
  assign chk_bus.pbit = i_desc_pbit;
  assign chk_bus.abit = i_desc_abit;
  assign chk_bus.selector = i_desc_selector;

  // Descriptor checks; unlisted fields never reach it
  legacy_ref_checker legacy_ref_checker_inst ( // RULE4
    .chk(chk_bus)
  );

  // Registered fault report, one cycle after the request
  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gp_ff <= 1'b0;
      ss_ff <= 1'b0;
      prio_ff <= 1'b0;
      err_ff <= ERR_ZERO;
    end
    else
    begin
      gp_ff <= chk_bus.fkind == FAULT_GP;
      ss_ff <= chk_bus.fkind == FAULT_STACK; // RULE10
      prio_ff <= chk_bus.high_prio; // RULE5
      err_ff <= chk_bus.err_code; // RULE9
    end
  end

  // Writable bits only; fixed one at bit 1, zeros elsewhere
  always_comb
  begin
    nxt_flags = (i_flags_wdata & FLAGS_WR_MASK) | FLAGS_ONES; // RULE12 RULE13 RULE14 RULE15
  end

  // Flags only change on explicit writes, so state persists across set switches
  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn) flags_ff <= FLAGS_RESET;
    else if (i_flags_wr) flags_ff <= nxt_flags; // RULE18
  end

  // Flags feed only legacy checks and the view; native path never sees them
  assign o_general_protection_fault = gp_ff; // RULE17
  assign o_stack_fault = ss_ff;
  assign o_fault_high_prio = prio_ff;
  assign o_fault_err_code = err_ff;
  assign o_legacy_flags_word = flags_ff;
  assign o_virtual_8086_mode = flags_ff[VM_POS];

  // Reads always show bit 1 set and bits 3, 5, 15 clear
  a_flags_fixed_bits: assert property (@(posedge i_core_clk) disable iff (!rstn)
    flags_ff[ONE_POS] && !flags_ff[Z3_POS] && !flags_ff[Z5_POS] && !flags_ff[Z15_POS]) // RULE14
    else $error("fixed flag bits wrong");
  a_flags_reserved_zero: assert property (@(posedge i_core_clk) disable iff (!rstn)
    flags_ff[63:22] == 42'h0) // RULE16
    else $error("reserved flag bits set");
  a_flags_write_lands: assert property (@(posedge i_core_clk) disable iff (!rstn)
    i_flags_wr |=> flags_ff[ID_POS:CF_POS] == ($past(i_flags_wdata[21:0]) & 22'h3F_7FD5 | 22'h2)) // RULE12
    else $error("flag write not stored");
  a_flags_hold: assert property (@(posedge i_core_clk) disable iff (!rstn)
    !i_flags_wr |=> $stable(flags_ff)) // RULE18
    else $error("flags changed without write");
  a_no_check_switch: assert property (@(posedge i_core_clk) disable iff (!rstn)
    (i_iset_switch || !i_legacy_active) |=> !gp_ff && !ss_ff) // RULE3
    else $error("fault outside legacy check");
  a_fetch_prio_zero: assert property (@(posedge i_core_clk) disable iff (!rstn)
    prio_ff |-> gp_ff && err_ff == 16'h0000) // RULE5
    else $error("fetch fault not high-prio zero");
  a_stack_fault_kind: assert property (@(posedge i_core_clk) disable iff (!rstn)
    (chk_bus.req && i_ref_kind == REF_SS && chk_bus.fault) |=> ss_ff && !gp_ff) // RULE10
    else $error("stack ref not stack fault");
  a_cs_rw_skip: assert property (@(posedge i_core_clk) disable iff (!rstn)
    (chk_bus.req && i_ref_kind == REF_CS && mode != MODE_VM86 && i_desc_sbit && i_desc_pbit && i_desc_abit
     && !(mode == MODE_PROT)) |=> !gp_ff) // RULE8
    else $error("real mode code rw checked");
  a_table_selector: assert property (@(posedge i_core_clk) disable iff (!rstn)
    (chk_bus.req && i_ref_kind == REF_TABLE && !i_desc_pbit) |=> gp_ff && err_ff == $past(i_desc_selector)) // RULE9
    else $error("table fault code wrong");
  a_real_cpl_fetch: assert property (@(posedge i_core_clk) disable iff (!rstn)
    (chk_bus.req && i_ref_kind == REF_FETCH && mode == MODE_REAL && i_current_privilege_level != 2'h0)
    |=> gp_ff && prio_ff) // RULE11
    else $error("real mode privilege not checked");

  // Fault report checks: kinds, codes and quiet cycles

  // Fault kinds never overlap; stack faults carry no priority
  a_stack_no_gp: assert property (@(posedge i_core_clk) disable iff (!rstn)
    ss_ff |-> !gp_ff && !prio_ff) // RULE10
    else $error("stack fault overlaps general fault");

  // No accepted request, no report in the next cycle
  a_no_ref_quiet: assert property (@(posedge i_core_clk) disable iff (!rstn)
    !chk_bus.req |=> !gp_ff && !ss_ff && !prio_ff && err_ff == ERR_ZERO) // RULE2
    else $error("fault without accepted request");

  // Any fault outside the table kinds reports code zero
  a_gp_zero_code: assert property (@(posedge i_core_clk) disable iff (!rstn)
    (chk_bus.fault && i_ref_kind != REF_TABLE) |=> err_ff == ERR_ZERO) // RULE9
    else $error("non-table fault code not zero");

  // Expand-down data type is never fetched from
  a_fetch_expdn: assert property (@(posedge i_core_clk) disable iff (!rstn)
    (chk_bus.req && i_ref_kind == REF_FETCH && (i_desc_type & TYPE_CODE_BIT) == 4'h0
     && (i_desc_type & TYPE_EXPDN_BIT) != 4'h0) |=> gp_ff && prio_ff) // RULE6
    else $error("expand-down fetch not faulted");

  // Virtual-8086 fetch needs privilege 3
  a_vm86_fetch_cpl: assert property (@(posedge i_core_clk) disable iff (!rstn)
    (chk_bus.req && i_ref_kind == REF_FETCH && mode == MODE_VM86 && i_current_privilege_level != CPL_VM86)
    |=> gp_ff && prio_ff && err_ff == ERR_ZERO) // RULE11
    else $error("virtual-8086 privilege not checked");

  // Protected mode: reading unreadable code faults
  a_cs_prot_read: assert property (@(posedge i_core_clk) disable iff (!rstn)
    (chk_bus.req && i_ref_kind == REF_CS && mode == MODE_PROT && !i_ref_write
     && (i_desc_type & (TYPE_CODE_BIT | TYPE_RD_BIT)) == TYPE_CODE_BIT) |=> gp_ff && !ss_ff) // RULE7
    else $error("unreadable code read not faulted");

  // Protected fetch ignores privilege, dpl and size fields
  a_unlisted_fields: assert property (@(posedge i_core_clk) disable iff (!rstn)
    (chk_bus.req && i_ref_kind == REF_FETCH && mode == MODE_PROT && i_desc_sbit && i_desc_pbit && i_desc_abit
     && ((i_desc_type & TYPE_CODE_BIT) != 4'h0 || (i_desc_type & TYPE_EXPDN_BIT) == 4'h0)) |=> !gp_ff) // RULE4
    else $error("unlisted field faulted a fetch");

  // Wide stack segment faults in virtual-8086 mode
  a_ss_vm86_size: assert property (@(posedge i_core_clk) disable iff (!rstn)
    (chk_bus.req && i_ref_kind == REF_SS && mode == MODE_VM86 && i_desc_dbit) |=> ss_ff && !gp_ff) // RULE10
    else $error("wide virtual-8086 stack not faulted");
endmodule // legacy_env_integrity_check

// ### testbench/legacy_env_integrity_check_tb.sv
// Self-checking bench for the legacy environment integrity checker
`timescale 1ns/1ps
module legacy_env_integrity_check_tb;
  import legacy_env_pkg::*;
  typedef struct packed {logic gp; logic st; logic hp; logic [15:0] err;} fault_note_s;
  logic i_core_clk, i_rstn, i_legacy_active, i_iset_switch, i_protection_on;
  logic [1:0] i_current_privilege_level;
  logic i_ref_valid, i_ref_write;
  ref_kind_e i_ref_kind;
  logic [3:0] i_desc_type;
  logic [1:0] i_desc_dpl;
  logic i_desc_dbit, i_desc_sbit, i_desc_pbit, i_desc_abit;
  logic [15:0] i_desc_selector;
  logic i_flags_wr, i_flags_wr_legacy;
  logic [63:0] i_flags_wdata;
  logic o_general_protection_fault, o_stack_fault, o_fault_high_prio, o_virtual_8086_mode;
  logic [15:0] o_fault_err_code;
  logic [63:0] o_legacy_flags_word;
  fault_note_s fault_q[$];
  logic [64:0] flag_q[$];
  fault_note_s fault_seen;
  logic [64:0] flags_seen;
  logic ref_seen = 1'b0;
  logic wr_seen = 1'b0;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;

  legacy_env_integrity_check legacy_env_integrity_check_inst (.*);

  // Outputs gathered into the shape of the notes
  assign fault_seen = {o_general_protection_fault, o_stack_fault, o_fault_high_prio, o_fault_err_code};
  assign flags_seen = {o_virtual_8086_mode, o_legacy_flags_word};

  // Free-running core clock, 50 ns period
  initial
  begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp_fault(input fault_note_s e, input fault_note_s g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch fault report exp %h got %h", e, g);
    end
  endtask

  task automatic cmp_flags(input logic [64:0] e, input logic [64:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch flags word exp %h got %h", e, g);
    end
  endtask

  // Flags view expected from written data; bit 17 also drives the mode output
  function automatic logic [64:0] flags_exp(input logic [63:0] d);
    return {d[17], 42'h0, d[21:16], 1'b0, d[14:6], 1'b0, d[4], 1'b0, d[2], 1'b1, d[0]};
  endfunction

  task automatic wr_flags(input logic [63:0] d);
    @(negedge i_core_clk);
    i_flags_wr = 1'b1;
    i_flags_wdata = d;
    i_flags_wr_legacy = d[0];
    flag_q.push_back(flags_exp(d));
    @(negedge i_core_clk);
    i_flags_wr = 1'b0;
  endtask

  // One request; dpl follows cpl except for data and table references, where the field goes unchecked
  task automatic do_ref(input ref_kind_e k, input logic wr, input logic [1:0] cpl, input logic [3:0] ty,
    input logic sb, input logic gp, input logic st);
    fault_note_s n;
    @(negedge i_core_clk);
    i_ref_valid = 1'b1;
    i_ref_kind = k;
    i_ref_write = wr;
    i_current_privilege_level = cpl;
    i_desc_type = ty;
    i_desc_sbit = sb;
    i_desc_selector = 16'($urandom());
    i_desc_dpl = (k == REF_DATA || k == REF_TABLE) ? 2'($urandom()) : cpl;
    n.gp = gp;
    n.st = st;
    n.hp = gp && (k == REF_FETCH);
    n.err = (gp && k == REF_TABLE) ? i_desc_selector : ERR_ZERO;
    fault_q.push_back(n);
  endtask

  task automatic idle(input string name);
    @(negedge i_core_clk);
    i_ref_valid = 1'b0;
    repeat (2) @(negedge i_core_clk);
    $display("test %s done", name);
  endtask

  // Outputs are registered, so compare on the falling edge after the taking edge
  always @(posedge i_core_clk)
  begin
    ref_seen <= i_ref_valid;
    wr_seen <= i_flags_wr;
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      give_verdict();
    end
  end

  always @(negedge i_core_clk)
  begin
    if (ref_seen && fault_q.size() > 0)
      cmp_fault(fault_q.pop_front(), fault_seen);
    if (wr_seen && flag_q.size() > 0)
      cmp_flags(flag_q.pop_front(), flags_seen);
  end

  initial
  begin
    {i_rstn, i_iset_switch, i_protection_on, i_ref_valid, i_ref_write, i_flags_wr, i_flags_wr_legacy} = '0;
    {i_current_privilege_level, i_desc_type, i_desc_dpl, i_desc_dbit, i_desc_selector, i_flags_wdata} = '0;
    {i_legacy_active, i_desc_sbit, i_desc_pbit, i_desc_abit} = 4'hf;
    i_ref_kind = REF_FETCH;
    void'($urandom(32'h125f));
    repeat (16) @(negedge i_core_clk);
    i_rstn = 1'b1;
    repeat (3) @(negedge i_core_clk);
    cmp_flags(65'h2, {o_virtual_8086_mode, o_legacy_flags_word});
    wr_flags(64'hffff_ffff_ffff_ffff);
    for (int i = 0; i < 8; i++)
      wr_flags({42'h0, 22'($urandom())});
    wr_flags(64'h0000_0000_0000_0000);
    idle("flags");
    do_ref(REF_FETCH, 1'b0, 2'h0, 4'h2, 1'b1, 1'b0, 1'b0);
    do_ref(REF_FETCH, 1'b0, 2'h1, 4'h2, 1'b1, 1'b1, 1'b0);
    do_ref(REF_FETCH, 1'b0, 2'h0, 4'h6, 1'b1, 1'b1, 1'b0);
    do_ref(REF_FETCH, 1'b0, 2'h0, 4'ha, 1'b1, 1'b0, 1'b0);
    do_ref(REF_CS, 1'b1, 2'h0, 4'h0, 1'b1, 1'b0, 1'b0);
    do_ref(REF_SS, 1'b1, 2'h0, 4'h0, 1'b1, 1'b0, 1'b1);
    do_ref(REF_DATA, 1'b1, 2'h0, 4'h0, 1'b1, 1'b1, 1'b0);
    do_ref(REF_DATA, 1'b0, 2'h0, 4'h0, 1'b1, 1'b0, 1'b0);
    idle("real");
    i_legacy_active = 1'b0;
    do_ref(REF_FETCH, 1'b0, 2'h1, 4'h6, 1'b1, 1'b0, 1'b0);
    idle("native");
    cmp_flags(65'h2, {o_virtual_8086_mode, o_legacy_flags_word});
    i_legacy_active = 1'b1;
    i_iset_switch = 1'b1;
    do_ref(REF_FETCH, 1'b0, 2'h1, 4'h6, 1'b1, 1'b0, 1'b0);
    idle("switch");
    i_iset_switch = 1'b0;
    i_protection_on = 1'b1;
    do_ref(REF_FETCH, 1'b0, 2'h2, 4'ha, 1'b1, 1'b0, 1'b0);
    do_ref(REF_CS, 1'b0, 2'h0, 4'h8, 1'b1, 1'b1, 1'b0);
    do_ref(REF_CS, 1'b0, 2'h0, 4'ha, 1'b1, 1'b0, 1'b0);
    do_ref(REF_CS, 1'b1, 2'h0, 4'h0, 1'b1, 1'b1, 1'b0);
    do_ref(REF_CS, 1'b1, 2'h0, 4'h2, 1'b1, 1'b0, 1'b0);
    do_ref(REF_SS, 1'b1, 2'h1, 4'h0, 1'b1, 1'b0, 1'b1);
    do_ref(REF_TABLE, 1'b0, 2'h0, 4'h2, 1'b1, 1'b1, 1'b0);
    do_ref(REF_TABLE, 1'b0, 2'h0, 4'h2, 1'b0, 1'b0, 1'b0);
    idle("protected");
    i_desc_pbit = 1'b0;
    do_ref(REF_TABLE, 1'b0, 2'h0, 4'h2, 1'b0, 1'b1, 1'b0);
    idle("table");
    i_desc_pbit = 1'b1;
    wr_flags(64'h0000_0000_0002_0000);
    do_ref(REF_FETCH, 1'b0, 2'h3, 4'h2, 1'b1, 1'b0, 1'b0);
    do_ref(REF_FETCH, 1'b0, 2'h0, 4'h2, 1'b1, 1'b1, 1'b0);
    do_ref(REF_CS, 1'b1, 2'h3, 4'h0, 1'b1, 1'b0, 1'b0);
    do_ref(REF_SS, 1'b1, 2'h3, 4'h0, 1'b1, 1'b0, 1'b1);
    idle("virtual");
    i_desc_dbit = 1'b1;
    do_ref(REF_SS, 1'b0, 2'h3, 4'h2, 1'b1, 1'b0, 1'b1);
    idle("wide stack");
    i_desc_dbit = 1'b0;
    if (fault_q.size() != 0 || flag_q.size() != 0)
      errors++;
    give_verdict();
  end
endmodule // legacy_env_integrity_check_tb
